/* File: logic/lsd_pkg.sv */
// Constants shared by both ends of the scroll, duty and partial command link.
// Assumes one clock, sys_clk, on both ends and an active-low reset nrst.
package lsd_pkg;
    localparam logic [7:0] OP_AREA_SCROLL = 8'h10;
    localparam logic [7:0] OP_DUTY_SET = 8'h6D;
    localparam logic [6:0] OP_PARTIAL_ONOFF = 7'h4B;
    localparam logic [7:0] OP_PARTIAL_SET = 8'h32;
    localparam logic [7:0] OP_DISP_MODE = 8'h66;

    localparam int COM_LINES = 132;
    localparam logic [7:0] SCROLL_LINE_MAX = 8'h83;
    localparam logic [8:0] SCROLL_END_BIN_MAX = 9'h107;
    localparam logic [7:0] LINE_COUNT_MAX = 8'h84;
    localparam logic [5:0] DUTY_CODE_MAX = 6'h20;
    localparam logic [5:0] BLOCK_MAX = 6'h20;
    localparam logic [1:0] MODE_GRAY = 2'h0;
    localparam logic [1:0] MODE_BINARY = 2'h1;

    localparam logic [5:0] DUTY_RESET = 6'h20;
    localparam logic [5:0] BLOCK_RESET = 6'h00;
    localparam logic [7:0] COUNT_RESET = 8'h84;

    // Field positions in the parameter bytes and in the partial on/off command byte
    localparam int SCROLL_MODE_LSB = 0;
    localparam int END_BIT8_POS = 0;
    localparam int ONOFF_BIT_POS = 0;

    // Host register map, word indices on the plain port
    localparam logic [2:0] HREG_CMD = 3'h0;
    localparam logic [2:0] HREG_PARAM = 3'h1;
    localparam logic [2:0] HREG_DUTY = 3'h2;
    localparam logic [2:0] HREG_PARTIAL = 3'h3;
    localparam logic [2:0] HREG_STATUS = 3'h4;
    localparam int ST_BUSY_POS = 0;
    localparam int ST_DROP_POS = 1;
    localparam int ST_REJECT_POS = 2;
endpackage

/* File: logic/lsd_if.sv */
// Byte link from the host controller to the command decoder.
// One byte per cycle of sys_clk while wr_stb is high.
interface lsd_if;
    logic wr_stb;
    logic cmd_param_select;
    logic [7:0] wr_data;

    modport dev (input wr_stb, input cmd_param_select, input wr_data);
    modport host (output wr_stb, output cmd_param_select, output wr_data);
endinterface

/* File: logic/lsd_com_window.sv */
// Common line enable map from the duty code and the start block.
// Registered; follows its inputs one cycle later.
module lsd_com_window import lsd_pkg::*; #(
    parameter int LINES = COM_LINES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Settings
    input wire logic [5:0] duty_code,
    input wire logic [5:0] start_block,
    // Driven lines
    output logic [LINES-1:0] common_drive_line
);
    logic [LINES-1:0] map_ff;
    logic [LINES-1:0] nxt_map;
    wire [8:0] first_line = {1'b0, start_block, 2'b00};
    wire [8:0] span = {1'b0, duty_code, 2'b00} + 9'h004;

    genvar gi;
    generate
        for (gi = 0; gi < LINES; gi++) begin : g_line
            localparam logic [8:0] IDX = 9'(gi);
            wire [8:0] offs = (IDX >= first_line) ? IDX - first_line
                                                  : IDX + 9'(LINES) - first_line;
            assign nxt_map[gi] = offs < span;
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            map_ff <= '1;
        end else begin
            map_ff <= nxt_map;
        end
    end

    assign common_drive_line = map_ff;
endmodule

/* File: logic/lsd_dev_end.sv */
// Command decoder of the display driver: scroll, duty, partial and mode.
// Assumes the host link is synchronous to sys_clk, one byte per strobe.
//
// The address-and-strobe port and the register offsets were left to the implementer.
module lsd_dev_end import lsd_pkg::*; #(
    parameter int LINES = COM_LINES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Host link
    lsd_if.dev link,
    // Area scroll settings
    output logic [1:0] scroll_mode,
    output logic [7:0] scroll_start,
    output logic [8:0] scroll_end,
    output logic [7:0] scroll_count,
    // Duty and block settings
    output logic [5:0] duty_code,
    output logic [7:0] duty_lines,
    output logic [5:0] start_block,
    // Partial display settings
    output logic partial_on,
    output logic [7:0] part_start,
    output logic [7:0] part_count,
    // Display mode
    output logic disp_binary,
    // Driven common lines
    output logic [LINES-1:0] common_drive_line
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SCROLL = 5'b00010,
        ST_DUTY = 5'b00100,
        ST_PSET = 5'b01000,
        ST_DMODE = 5'b10000
    } lsd_dstate_t;

    lsd_dstate_t state_ff;
    lsd_dstate_t nxt_state;
    logic [2:0] idx_ff;
    logic [2:0] nxt_idx;
    logic [1:0] scroll_mode_ff;
    logic [7:0] scroll_start_ff;
    logic [8:0] scroll_end_ff;
    logic [7:0] end_low_ff;
    logic [7:0] scroll_count_ff;
    logic [5:0] duty_code_ff;
    logic [5:0] start_block_ff;
    logic partial_on_ff;
    logic [7:0] part_start_ff;
    logic [7:0] part_count_ff;
    logic disp_binary_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Byte classification and opcode decode

    wire [7:0] din = link.wr_data;
    wire is_cmd = link.wr_stb & ~link.cmd_param_select;
    wire is_par = link.wr_stb & link.cmd_param_select;
    wire op_scroll = is_cmd & (din == OP_AREA_SCROLL);
    wire op_duty = is_cmd & (din == OP_DUTY_SET);
    wire op_onoff = is_cmd & (din[7:1] == OP_PARTIAL_ONOFF);
    wire op_pset = is_cmd & (din == OP_PARTIAL_SET);
    wire op_dmode = is_cmd & (din == OP_DISP_MODE);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter sequencing

    // The scroll sequence length follows the mode held when the bytes arrive
    wire [2:0] scroll_last = disp_binary_ff ? 3'h4 : 3'h3;
    wire [2:0] last_idx = (state_ff == ST_SCROLL) ? scroll_last :
                          (state_ff == ST_DMODE) ? 3'h0 : 3'h1;
    wire seq_end = is_par & (idx_ff == last_idx);

    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        if (is_cmd) begin
            nxt_idx = 3'h0;
            nxt_state = op_scroll ? ST_SCROLL :
                        op_duty ? ST_DUTY :
                        op_pset ? ST_PSET :
                        op_dmode ? ST_DMODE : ST_IDLE;
        end else if (is_par && state_ff != ST_IDLE) begin
            nxt_idx = seq_end ? 3'h0 : idx_ff + 3'h1;
            nxt_state = seq_end ? ST_IDLE : state_ff;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            idx_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Field loads, each gated by its position, and all but scroll mode and the end low byte by legality

    wire in_scroll = is_par & (state_ff == ST_SCROLL);
    wire in_duty = is_par & (state_ff == ST_DUTY);
    wire in_pset = is_par & (state_ff == ST_PSET);
    wire in_dmode = is_par & (state_ff == ST_DMODE);
    wire [8:0] end_bin = {din[END_BIT8_POS], end_low_ff};
    wire line_ok = din <= SCROLL_LINE_MAX;
    wire count_ok = (din != 8'h00) && (din <= LINE_COUNT_MAX);

    wire ld_mode = in_scroll & (idx_ff == 3'h0);
    wire ld_start = in_scroll & (idx_ff == 3'h1) & line_ok;
    wire ld_end_low = in_scroll & (idx_ff == 3'h2);
    wire ld_end_gray = ld_end_low & ~disp_binary_ff & line_ok;
    wire ld_end_bin = in_scroll & (idx_ff == 3'h3) & disp_binary_ff
                      & (end_bin <= SCROLL_END_BIN_MAX);
    wire ld_count = in_scroll & (idx_ff == scroll_last) & count_ok;
    wire ld_duty = in_duty & (idx_ff == 3'h0) & (din[5:0] <= DUTY_CODE_MAX);
    wire ld_block = in_duty & (idx_ff == 3'h1) & (din[5:0] <= BLOCK_MAX);
    wire ld_pstart = in_pset & (idx_ff == 3'h0) & (din <= LINE_COUNT_MAX);
    wire ld_pcount = in_pset & (idx_ff == 3'h1) & count_ok;
    wire ld_dmode = in_dmode & (din[7:2] == 6'h00) & (din[1] == 1'b0);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            scroll_mode_ff <= 2'h0;
            scroll_start_ff <= 8'h00;
            end_low_ff <= 8'h00;
            scroll_end_ff <= 9'h000;
            scroll_count_ff <= COUNT_RESET;
        end else begin
            if (ld_mode) begin
                scroll_mode_ff <= din[SCROLL_MODE_LSB +: 2];
            end
            if (ld_start) begin
                scroll_start_ff <= din;
            end
            if (ld_end_low) begin
                end_low_ff <= din;
            end
            if (ld_end_gray) begin
                scroll_end_ff <= {1'b0, din};
            end else if (ld_end_bin) begin
                scroll_end_ff <= end_bin;
            end
            if (ld_count) begin
                scroll_count_ff <= din;
            end
        end
    end

    // Duty changes only through its own command, never by partial display
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            duty_code_ff <= DUTY_RESET;
            start_block_ff <= BLOCK_RESET;
        end else begin
            if (ld_duty) begin
                duty_code_ff <= din[5:0];
            end
            if (ld_block) begin
                start_block_ff <= din[5:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            partial_on_ff <= 1'b0;
            part_start_ff <= 8'h00;
            part_count_ff <= COUNT_RESET;
            disp_binary_ff <= 1'b0;
        end else begin
            if (op_onoff) begin
                partial_on_ff <= din[ONOFF_BIT_POS];
            end
            if (ld_pstart) begin
                part_start_ff <= din;
            end
            if (ld_pcount) begin
                part_count_ff <= din;
            end
            if (ld_dmode) begin
                disp_binary_ff <= din[0] == MODE_BINARY[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Common line window

    lsd_com_window #(
        .LINES(LINES)
    ) u_window (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .duty_code(duty_code_ff),
        .start_block(start_block_ff),
        .common_drive_line(common_drive_line)
    );

    assign scroll_mode = scroll_mode_ff;
    assign scroll_start = scroll_start_ff;
    assign scroll_end = scroll_end_ff;
    assign scroll_count = scroll_count_ff;
    assign duty_code = duty_code_ff;
    assign duty_lines = {duty_code_ff, 2'b00} + 8'h04;
    assign start_block = start_block_ff;
    assign partial_on = partial_on_ff;
    assign part_start = part_start_ff;
    assign part_count = part_count_ff;
    assign disp_binary = disp_binary_ff;
endmodule

/* File: logic/lsd_host_end.sv */
// Host-side controller that turns register writes into link bytes.
// Software uses the plain port; read data stand one cycle after the strobe.
module lsd_host_end import lsd_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Device link
    lsd_if.host link
);
    logic [8:0] q_ff [3];
    logic [1:0] q_cnt_ff;
    logic stb_ff;
    logic sel_ff;
    logic [7:0] dat_ff;
    logic drop_ff;
    logic reject_ff;
    logic [11:0] duty_shadow_ff;
    logic [15:0] rdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    wire busy = q_cnt_ff != 2'h0;
    wire wr_cmd = reg_wr & (reg_addr == HREG_CMD);
    wire wr_par = reg_wr & (reg_addr == HREG_PARAM);
    wire wr_duty = reg_wr & (reg_addr == HREG_DUTY);
    wire wr_part = reg_wr & (reg_addr == HREG_PARTIAL);
    wire wr_stat = reg_wr & (reg_addr == HREG_STATUS);
    wire [5:0] w_code = reg_wdata[5:0];
    wire [5:0] w_block = reg_wdata[13:8];
    wire [8:0] part_sum = {1'b0, reg_wdata[7:0]} + {1'b0, reg_wdata[15:8]};
    wire duty_bad = (w_code > DUTY_CODE_MAX) | (w_block > BLOCK_MAX);
    wire part_bad = part_sum > 9'(COM_LINES);
    wire want = wr_cmd | wr_par | wr_duty | wr_part;
    wire bad = (wr_duty & duty_bad) | (wr_part & part_bad);
    wire load = want & ~busy & ~bad;
    wire drop = want & busy;

    ////////////////////////////////////////////////////////////////////////////
    // Byte queue; duty and partial requests go out as adjacent bytes

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 3; i++) begin
                q_ff[i] <= 9'h000;
            end
            q_cnt_ff <= 2'h0;
        end else if (load) begin
            if (wr_duty) begin
                q_ff[0] <= {1'b0, OP_DUTY_SET};
                q_ff[1] <= {3'h4, w_code};
                q_ff[2] <= {3'h4, w_block};
                q_cnt_ff <= 2'h3;
            end else if (wr_part) begin
                q_ff[0] <= {1'b0, OP_PARTIAL_SET};
                q_ff[1] <= {1'b1, reg_wdata[7:0]};
                q_ff[2] <= {1'b1, reg_wdata[15:8]};
                q_cnt_ff <= 2'h3;
            end else begin
                q_ff[0] <= {wr_par, reg_wdata[7:0]};
                q_cnt_ff <= 2'h1;
            end
        end else if (busy) begin
            q_ff[0] <= q_ff[1];
            q_ff[1] <= q_ff[2];
            q_cnt_ff <= q_cnt_ff - 2'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stb_ff <= 1'b0;
            sel_ff <= 1'b0;
            dat_ff <= 8'h00;
        end else begin
            stb_ff <= busy;
            sel_ff <= busy ? q_ff[0][8] : 1'b0;
            dat_ff <= busy ? q_ff[0][7:0] : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status and read-back; a new event wins over a clear in the same cycle

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            drop_ff <= 1'b0;
            reject_ff <= 1'b0;
            duty_shadow_ff <= {BLOCK_RESET, DUTY_RESET};
        end else begin
            drop_ff <= drop | (drop_ff & ~(wr_stat & reg_wdata[ST_DROP_POS]));
            reject_ff <= (bad & ~busy)
                         | (reject_ff & ~(wr_stat & reg_wdata[ST_REJECT_POS]));
            if (load & wr_duty) begin
                duty_shadow_ff <= {w_block, w_code};
            end
        end
    end

    wire [15:0] status_word = {13'h0000, reject_ff, drop_ff, busy};
    wire [15:0] rd_mux = (reg_addr == HREG_STATUS) ? status_word :
                         (reg_addr == HREG_DUTY) ?
                         {2'b00, duty_shadow_ff[11:6], 2'b00, duty_shadow_ff[5:0]} :
                         16'h0000;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    assign reg_rdata = rdata_ff;
    assign link.wr_stb = stb_ff;
    assign link.cmd_param_select = sel_ff;
    assign link.wr_data = dat_ff;
endmodule

/* File: tb/lsd_link_assertions.sv */
// Concurrent checks on the byte link between the host end and the device end.
// Instantiated in the bench beside the link interface; sees the link signals only.
module lsd_link_assertions import lsd_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link
    input wire logic wr_stb,
    input wire logic cmd_param_select,
    input wire logic [7:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    wire op_duty = wr_stb && !cmd_param_select && wr_data == OP_DUTY_SET;
    wire op_part = wr_stb && !cmd_param_select && wr_data == OP_PARTIAL_SET;
    wire par = wr_stb && cmd_param_select;

    ////////////////////////////////////////////////////////////////////////////////
    a_duty_pair_adjacent: assert property (op_duty |=> par ##1 par)
        else $error("duty parameters not adjacent");
    a_duty_code_max: assert property (op_duty |=> wr_data <= {2'h0, DUTY_CODE_MAX})
        else $error("duty code above limit sent");
    a_block_max: assert property (op_duty |=> ##1 wr_data <= {2'h0, BLOCK_MAX})
        else $error("start block above limit sent");
    a_duty_bits_clear: assert property (op_duty |=> !wr_data[7:6] ##1 !wr_data[7:6])
        else $error("unused duty bits set");
    a_part_pair: assert property (op_part |=> par ##1 par)
        else $error("partial parameters missing");
    a_part_start_max: assert property (op_part |=> wr_data <= LINE_COUNT_MAX)
        else $error("partial start above limit");
    // Host end must filter windows that run past the last line
    a_part_sum_limit: assert property (op_part ##2 1'b1 |->
        ({1'b0, $past(wr_data)} + {1'b0, wr_data}) <= 9'h084)
        else $error("partial window beyond last line");
    a_reset_idle: assert property (disable iff (1'b0) !nrst |-> !wr_stb && !cmd_param_select)
        else $error("link active during reset");

    ////////////////////////////////////////////////////////////////////////////////
    c_duty: cover property (op_duty ##1 par ##1 par);
    c_part: cover property (op_part ##2 par);
    c_scroll: cover property (wr_stb && !cmd_param_select && wr_data == OP_AREA_SCROLL ##1 par);
endmodule

/* File: tb/tb_top.sv */
// Bench for both ends: register port of the host end down to device settings.
// Only the host register port is driven; the device sees what the host end sends.
module tb_top import lsd_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [1:0] scroll_mode;
    logic [7:0] scroll_start, scroll_count, duty_lines, part_start, part_count;
    logic [8:0] scroll_end;
    logic [5:0] duty_code, start_block;
    logic partial_on, disp_binary;
    logic [COM_LINES-1:0] common_drive_line;
    int n_fail = 0;
    int checks_done = 0;
    logic [1:0] e_mode = 2'h0;
    logic [7:0] e_start = 8'h00, e_cnt = 8'h84, e_ps = 8'h00, e_pc = 8'h84;
    logic [8:0] e_end = 9'h000;
    logic [5:0] e_code = 6'h20, e_blk = 6'h00;
    logic e_pon = 1'b0, e_bin = 1'b0;

    lsd_if link_if ();
    lsd_host_end i_lsd_host_end (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .link(link_if));
    lsd_dev_end i_lsd_dev_end (.sys_clk(sys_clk), .nrst(nrst), .link(link_if),
        .scroll_mode(scroll_mode), .scroll_start(scroll_start), .scroll_end(scroll_end),
        .scroll_count(scroll_count), .duty_code(duty_code), .duty_lines(duty_lines),
        .start_block(start_block), .partial_on(partial_on), .part_start(part_start),
        .part_count(part_count), .disp_binary(disp_binary),
        .common_drive_line(common_drive_line));
    lsd_link_assertions i_lsd_link_assertions (.sys_clk(sys_clk), .nrst(nrst),
        .wr_stb(link_if.wr_stb), .cmd_param_select(link_if.cmd_param_select),
        .wr_data(link_if.wr_data));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [COM_LINES-1:0] win(input logic [5:0] code, input logic [5:0] blk);
        logic [COM_LINES-1:0] m;
        m = '0;
        for (int i = 0; i < COM_LINES; i++) begin
            m[i] = ((i + COM_LINES - 4 * blk) % COM_LINES) < 4 * (code + 1);
        end
        return m;
    endfunction

    task automatic results();
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [COM_LINES-1:0] got, input logic [COM_LINES-1:0] exp,
        input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Settles the device too: settings lag the last byte, the line map one more cycle
    task automatic wait_idle();
        logic [15:0] s;
        for (int k = 0; k < 40; k++) begin
            reg_read(HREG_STATUS, s);
            if (s[ST_BUSY_POS] === 1'b0) begin
                repeat (3) @(posedge sys_clk);
                return;
            end
        end
        n_fail++;
        $display("[FAIL] %0t busy never cleared", $time);
        results();
    endtask

    task automatic send(input logic sel, input logic [7:0] b);
        reg_write(sel ? HREG_PARAM : HREG_CMD, {8'h00, b});
        wait_idle();
    endtask

    task automatic check_all();
        chk(scroll_mode, e_mode, "scroll mode");
        chk(scroll_start, e_start, "scroll start");
        chk(scroll_end, e_end, "scroll end");
        chk(scroll_count, e_cnt, "scroll count");
        chk(duty_code, e_code, "duty code");
        chk(duty_lines, 8'(4 * (e_code + 1)), "duty lines");
        chk(start_block, e_blk, "start block");
        chk(common_drive_line, win(e_code, e_blk), "driven lines");
        chk(partial_on, e_pon, "partial on");
        chk(part_start, e_ps, "partial start");
        chk(part_count, e_pc, "partial count");
        chk(disp_binary, e_bin, "display mode");
    endtask

    task automatic scroll(input logic [7:0] mb, input logic [7:0] s, input logic [8:0] e,
        input logic [7:0] c);
        send(1'b0, OP_AREA_SCROLL);
        send(1'b1, mb);
        send(1'b1, s);
        send(1'b1, e[7:0]);
        if (e_bin) send(1'b1, {7'h55, e[8]});
        send(1'b1, c);
        e_mode = mb[1:0];
        if (s <= SCROLL_LINE_MAX) e_start = s;
        if (e <= (e_bin ? SCROLL_END_BIN_MAX : {1'b0, SCROLL_LINE_MAX})) e_end = e;
        if (c != 8'h00 && c <= LINE_COUNT_MAX) e_cnt = c;
        check_all();
    endtask

    task automatic status_reject(input logic exp, input string what);
        logic [15:0] r;
        reg_read(HREG_STATUS, r);
        chk(r[ST_REJECT_POS], exp, what);
        reg_write(HREG_STATUS, 16'h0006);
    endtask

    task automatic duty(input logic [5:0] c, input logic [5:0] b);
        logic ok;
        logic [15:0] r;
        ok = c <= DUTY_CODE_MAX && b <= BLOCK_MAX;
        reg_write(HREG_DUTY, {2'h0, b, 2'h0, c});
        wait_idle();
        status_reject(!ok, "duty reject");
        if (ok) begin
            e_code = c;
            e_blk = b;
        end
        // Read-back lets software confirm that paired chips got one duty
        reg_read(HREG_DUTY, r);
        chk(r, {2'h0, e_blk, 2'h0, e_code}, "duty readback");
        check_all();
    endtask

    task automatic part(input logic [7:0] s, input logic [7:0] c);
        logic ok;
        ok = ({1'b0, s} + {1'b0, c}) <= 9'h084;
        reg_write(HREG_PARTIAL, {c, s});
        wait_idle();
        status_reject(!ok, "partial reject");
        // Each byte is stored on its own; a zero count keeps the old count
        if (ok) begin
            e_ps = s;
        end
        if (ok && c != 8'h00) begin
            e_pc = c;
        end
        check_all();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] s, c;
        logic [15:0] r;
        nrst <= 1'b0;
        void'($urandom(32'hDD6E8E1D));
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check_all();
        for (int m = 0; m < 4; m++) begin
            scroll({6'($urandom), 2'(m)}, 8'($urandom_range(131)), 9'($urandom_range(131)),
                8'($urandom_range(132, 1)));
        end
        scroll(8'h03, 8'h83, 9'h083, 8'h84);
        scroll(8'h01, 8'h84, 9'h084, 8'h00);
        send(1'b0, OP_DISP_MODE);
        send(1'b1, 8'h02);
        check_all();
        send(1'b0, OP_DISP_MODE);
        send(1'b1, 8'h01);
        e_bin = 1'b1;
        scroll(8'h02, 8'h10, 9'h107, 8'h05);
        scroll(8'h00, 8'h20, 9'h108, 8'h40);
        scroll(8'h01, 8'h84, 9'h0C3, 8'h01);
        send(1'b0, OP_DISP_MODE);
        send(1'b1, 8'h00);
        e_bin = 1'b0;
        duty(6'h15, 6'h01);
        duty(6'h10, 6'h1A);
        duty(6'h21, 6'h02);
        duty(6'h00, 6'h21);
        for (int k = 0; k < 6; k++) begin
            duty(6'($urandom_range(32)), 6'($urandom_range(32)));
        end
        send(1'b0, {OP_PARTIAL_ONOFF, 1'b1});
        e_pon = 1'b1;
        check_all();
        duty(6'h07, 6'h03);
        part(8'h00, 8'h84);
        part(8'h40, 8'h45);
        part(8'h10, 8'h00);
        for (int k = 0; k < 4; k++) begin
            s = 8'($urandom_range(100));
            c = 8'($urandom_range(132 - s, 1));
            part(s, c);
        end
        // A write while the queue drains is dropped, so the duty pair stays intact
        reg_write(HREG_DUTY, 16'h0209);
        reg_write(HREG_CMD, {8'h00, OP_DUTY_SET});
        wait_idle();
        reg_read(HREG_STATUS, r);
        chk(r[2:0], 3'h2, "drop flag");
        reg_write(HREG_STATUS, 16'h0002);
        reg_read(HREG_STATUS, r);
        chk(r[2:0], 3'h0, "drop flag clear");
        e_code = 6'h09;
        e_blk = 6'h02;
        check_all();
        send(1'b0, {OP_PARTIAL_ONOFF, 1'b0});
        e_pon = 1'b0;
        check_all();
        // A new opcode cuts the scroll sequence; the stray byte after it is dropped
        send(1'b0, OP_AREA_SCROLL);
        send(1'b1, 8'h01);
        send(1'b0, {OP_PARTIAL_ONOFF, 1'b0});
        send(1'b1, 8'h05);
        e_mode = 2'h1;
        check_all();
        results();
    end
endmodule
